// File: fbm_cfg.svh
`ifndef FBM_CFG_SVH
`define FBM_CFG_SVH

// Media geometry: logical words, data slots, spare slots
`define FBM_NLOG 8
`define FBM_NDATA 16
`define FBM_NSPARE 4
`define FBM_NPHYS 20
`define FBM_CW_W 22

// Register selects on the address lines
`define FBM_DA_DATA 3'h0
`define FBM_DA_LADDR 3'h3
`define FBM_DA_ALT 3'h6
`define FBM_DA_CMD 3'h7

// Command codes
`define FBM_CMD_READ 8'h20
`define FBM_CMD_WRITE 8'h30

// Status bit positions
`define FBM_ST_BSY 7
`define FBM_ST_DRDY 6
`define FBM_ST_LOCK 5
`define FBM_ST_DRQ 3
`define FBM_ST_CORR 2
`define FBM_ST_ERR 0

// Reset values
`define FBM_RST_STROBE 1'h1
`define FBM_RST_CURSOR 4'h0

`endif

// File: fbm_pkg.sv
`include "fbm_cfg.svh"

package fbm_pkg;

  typedef enum logic [2:0] {
    FBM_IDLE = 3'b000,
    FBM_RD_FETCH = 3'b001,
    FBM_WR_WAIT = 3'b010,
    FBM_WR_PROG = 3'b011,
    FBM_REMAP = 3'b100
  } fbm_state_e_t;

  // Host-side pin inputs, sampled on the core clock
  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic [15:0] dd;
  } fbm_ata_in_t;

  // Block failure report from the media
  typedef struct packed {
    logic req;
    logic [3:0] slot;
  } fbm_fault_t;

  typedef struct packed {
    logic [15:0] data;
    logic single;
    logic dbl;
  } fbm_ecc_t;

  typedef struct packed {
    logic [1:0][15:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } fbm_fifo_st_t;

  typedef struct packed {
    fbm_state_e_t state;
    logic dior_q;
    logic diow_q;
    logic [2:0] lba;
    logic err;
    logic corr;
    logic [`FBM_NLOG-1:0][4:0] l2p;
    logic [`FBM_NLOG-1:0] l2p_ok;
    logic [`FBM_NPHYS-1:0] used;
    logic [`FBM_NDATA-1:0] bad;
    logic [3:0] cursor;
    logic [2:0] spares_used;
    logic fail_pend;
    logic [3:0] fail_slot;
    logic [15:0] wdata;
    logic [15:0] dd_out;
    logic oe;
  } fbm_core_st_t;

endpackage : fbm_pkg

// File: fbm_fifo2.sv
module fbm_fifo2 (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);

  fbm_pkg::fbm_fifo_st_t s;
  fbm_pkg::fbm_fifo_st_t next_s;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (s.cnt != 2'h2);
  assign out_valid = (s.cnt != 2'h0);
  assign out_data = s.mem[s.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Push and pop may happen in the same cycle
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = ~s.wp;
    end
    if (pop) begin
      next_s.rp = ~s.rp;
    end
    next_s.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : fbm_fifo2

// File: fbm_core.sv
// Operation
// - Spare blocks held back from ordinary data
// - Failed block remapped to spare, data copied
// - All spares used locks out programming
// - Reads still served while locked
// - Rewrites go to a fresh physical slot
// - Map tracks newest copy per logical address
// - ECC corrects any single-bit error
// - ECC detects any double-bit error
// - Transfers paced by host strobes, sampled on the core clock
// - Sixteen-bit data bus, registers on low byte
// - Write data captured at write strobe rise
// - Read data driven from read strobe fall
`include "fbm_cfg.svh"

module fbm_core (
  input wire logic clock,
  input wire logic sys_rst,
  input wire fbm_pkg::fbm_ata_in_t ata_in,
  output logic [15:0] dd_out,
  output logic dd_oe_n,
  output logic iordy,
  input wire fbm_pkg::fbm_fault_t fault,
  input wire logic [`FBM_CW_W-1:0] noise_mask,
  output logic locked,
  output logic [2:0] spares_left
);

  fbm_pkg::fbm_core_st_t s;
  fbm_pkg::fbm_core_st_t next_s;
  fbm_pkg::fbm_ecc_t dec;
  logic [`FBM_CW_W-1:0] flash [`FBM_NPHYS];
  logic [`FBM_CW_W-1:0] raw;
  logic [4:0] rd_addr;
  logic mem_we;
  logic [4:0] mem_wa;
  logic [`FBM_CW_W-1:0] mem_wd;
  logic [4:0] ff;
  logic [4:0] spare;
  logic [7:0] status;
  logic dior_fall, dior_rise, diow_rise;
  logic sel_cmd, sel_ctl, sel_data, cmd_take;
  logic wr_in_ready, wr_out_valid, wr_pop;
  logic [15:0] wr_out_data;
  logic rd_in_ready, rd_out_valid, rd_push, rd_pop;
  logic [15:0] rd_out_data, rd_in_data;

  // Hamming over positions 1..21, overall parity in bit 0
  function automatic logic [`FBM_CW_W-1:0] ecc_enc(input logic [15:0] d);
    logic [`FBM_CW_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int j = 1; j < `FBM_CW_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        c[j] = d[k];
        k++;
      end
    end
    for (int p = 0; p < 5; p++) begin
      for (int j = 1; j < `FBM_CW_W; j++) begin
        if (j[p]) c[1 << p] = c[1 << p] ^ c[j];
      end
    end
    c[0] = ^c[`FBM_CW_W-1:1];
    return c;
  endfunction : ecc_enc

  function automatic fbm_pkg::fbm_ecc_t ecc_dec(
      input logic [`FBM_CW_W-1:0] c);
    fbm_pkg::fbm_ecc_t r;
    logic [4:0] syn;
    logic [`FBM_CW_W-1:0] f;
    logic par;
    int k;
    syn = '0;
    for (int j = 1; j < `FBM_CW_W; j++) begin
      if (c[j]) syn = syn ^ 5'(j);
    end
    par = ^c;
    f = c;
    // Odd parity with a syndrome past the word is a multi-bit hit
    r.dbl = (!par && syn != 5'h00) || (par && syn > 5'h15);
    r.single = par && !r.dbl;
    if (r.single && syn != 5'h00) f[syn] = ~f[syn];
    r.data = '0;
    k = 0;
    for (int j = 1; j < `FBM_CW_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        r.data[k] = f[j];
        k++;
      end
    end
    return r;
  endfunction : ecc_dec

  // First free, good data slot at or after the cursor; never a spare
  function automatic logic [4:0] find_free(input logic [15:0] used,
      input logic [15:0] bad, input logic [3:0] cur);
    logic [4:0] r;
    logic [3:0] idx;
    r = '0;
    for (int i = 15; i >= 0; i--) begin
      idx = 4'(cur + 4'(i));
      if (!used[idx] && !bad[idx]) r = {1'b1, idx};
    end
    return r;
  endfunction : find_free

  // Strobe edges; inputs are synchronous to the core clock
  assign dior_fall = s.dior_q & ~ata_in.dior_n;
  assign dior_rise = ~s.dior_q & ata_in.dior_n;
  assign diow_rise = ~s.diow_q & ata_in.diow_n;
  assign sel_cmd = ~ata_in.cs0_n & ata_in.cs1_n;
  assign sel_ctl = ata_in.cs0_n & ~ata_in.cs1_n;
  assign sel_data = sel_cmd && ata_in.da == `FBM_DA_DATA;
  assign cmd_take = diow_rise && sel_cmd && ata_in.da == `FBM_DA_CMD
      && s.state == fbm_pkg::FBM_IDLE;

  // Derived status
  assign locked = (s.spares_used == 3'(`FBM_NSPARE));
  assign spares_left = 3'(3'(`FBM_NSPARE) - s.spares_used);
  assign spare = 5'h10 + {2'h0, s.spares_used};
  assign ff = find_free(s.used[`FBM_NDATA-1:0], s.bad, s.cursor);
  assign dd_out = s.dd_out;
  assign dd_oe_n = ~s.oe;

  always_comb begin
    status = '0;
    status[`FBM_ST_BSY] = s.state inside {fbm_pkg::FBM_RD_FETCH,
        fbm_pkg::FBM_WR_PROG, fbm_pkg::FBM_REMAP};
    status[`FBM_ST_DRDY] = 1'b1;
    status[`FBM_ST_LOCK] = locked;
    status[`FBM_ST_DRQ] = (s.state == fbm_pkg::FBM_WR_WAIT) | rd_out_valid;
    status[`FBM_ST_CORR] = s.corr;
    status[`FBM_ST_ERR] = s.err;
  end

  // One read port serves both host reads and the remap copy
  assign rd_addr = (s.state == fbm_pkg::FBM_REMAP) ?
      {1'b0, s.fail_slot} : s.l2p[s.lba];
  assign raw = flash[rd_addr] ^ noise_mask;
  assign dec = ecc_dec(raw);

  // Data port handshakes; iordy stretches a strobe the buffer can't take
  assign wr_pop = (s.state == fbm_pkg::FBM_WR_WAIT) & wr_out_valid;
  assign rd_pop = dior_rise & sel_data & rd_out_valid;
  assign rd_push = (s.state == fbm_pkg::FBM_RD_FETCH) & rd_in_ready
      & ~(s.l2p_ok[s.lba] & dec.dbl);
  assign rd_in_data = s.l2p_ok[s.lba] ? dec.data : 16'h0000;
  assign iordy = ~(sel_data && ((~ata_in.diow_n && ~wr_in_ready) ||
      (~ata_in.dior_n && ~rd_out_valid)));

  fbm_fifo2 u_wr_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(diow_rise & sel_data),
    .in_ready(wr_in_ready),
    .in_data(ata_in.dd),
    .out_valid(wr_out_valid),
    .out_ready(wr_pop),
    .out_data(wr_out_data)
  );

  fbm_fifo2 u_rd_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(rd_push),
    .in_ready(rd_in_ready),
    .in_data(rd_in_data),
    .out_valid(rd_out_valid),
    .out_ready(rd_pop),
    .out_data(rd_out_data)
  );

  // Next state: host port, media engine, failure intake
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    next_s.dior_q = ata_in.dior_n;
    next_s.diow_q = ata_in.diow_n;
    // Address only changes between commands, never mid-flight
    if (diow_rise && sel_cmd && ata_in.da == `FBM_DA_LADDR
        && s.state == fbm_pkg::FBM_IDLE) begin
      next_s.lba = ata_in.dd[2:0];
    end
    // Read data launched at the falling read strobe
    if (dior_fall && (sel_cmd || sel_ctl)) begin
      next_s.oe = 1'b1;
      if ((sel_cmd && ata_in.da == `FBM_DA_CMD) ||
          (sel_ctl && ata_in.da == `FBM_DA_ALT)) begin
        next_s.dd_out = {8'h00, status};
      end else if (sel_data) begin
        next_s.dd_out = rd_out_data;
      end else begin
        next_s.dd_out = 16'h0000;
      end
    end else if (ata_in.dior_n) begin
      next_s.oe = 1'b0;
    end
    case (s.state)
      fbm_pkg::FBM_IDLE: begin
        if (cmd_take) begin
          next_s.err = 1'b0;
          next_s.corr = 1'b0;
          if (ata_in.dd[7:0] == `FBM_CMD_READ) begin
            next_s.state = fbm_pkg::FBM_RD_FETCH;
          end else if (ata_in.dd[7:0] == `FBM_CMD_WRITE && !locked) begin
            next_s.state = fbm_pkg::FBM_WR_WAIT;
          end else begin
            next_s.err = 1'b1;
          end
        end else if (s.fail_pend) begin
          next_s.state = fbm_pkg::FBM_REMAP;
        end
      end
      fbm_pkg::FBM_RD_FETCH: begin
        if (rd_in_ready) begin
          if (s.l2p_ok[s.lba] && dec.dbl) begin
            next_s.err = 1'b1;
          end else if (s.l2p_ok[s.lba]) begin
            next_s.corr = dec.single;
          end
          next_s.state = fbm_pkg::FBM_IDLE;
        end
      end
      fbm_pkg::FBM_WR_WAIT: begin
        if (wr_pop) begin
          next_s.wdata = wr_out_data;
          next_s.state = fbm_pkg::FBM_WR_PROG;
        end
      end
      fbm_pkg::FBM_WR_PROG: begin
        if (ff[4]) begin
          mem_we = 1'b1;
          mem_wa = {1'b0, ff[3:0]};
          mem_wd = ecc_enc(s.wdata);
          if (s.l2p_ok[s.lba]) begin
            next_s.used[s.l2p[s.lba]] = 1'b0;
          end
          next_s.used[mem_wa] = 1'b1;
          next_s.l2p[s.lba] = mem_wa;
          next_s.l2p_ok[s.lba] = 1'b1;
          next_s.cursor = 4'(ff[3:0] + 4'h1);
        end else begin
          next_s.err = 1'b1;
        end
        next_s.state = fbm_pkg::FBM_IDLE;
      end
      fbm_pkg::FBM_REMAP: begin
        next_s.fail_pend = 1'b0;
        next_s.bad[s.fail_slot] = 1'b1;
        if (!locked && !s.bad[s.fail_slot]) begin
          next_s.spares_used = 3'(s.spares_used + 3'h1);
          if (s.used[s.fail_slot]) begin
            // A double hit is copied raw so it stays detectable
            mem_we = 1'b1;
            mem_wa = spare;
            mem_wd = dec.dbl ? raw : ecc_enc(dec.data);
            next_s.used[{1'b0, s.fail_slot}] = 1'b0;
            next_s.used[spare] = 1'b1;
            for (int i = 0; i < `FBM_NLOG; i++) begin
              if (s.l2p_ok[i] && s.l2p[i] == {1'b0, s.fail_slot}) begin
                next_s.l2p[i] = spare;
              end
            end
          end
        end
        next_s.state = fbm_pkg::FBM_IDLE;
      end
      default: begin
        next_s.state = fbm_pkg::FBM_IDLE;
      end
    endcase
    // New report wins over the clear in the remap cycle
    if (fault.req) begin
      next_s.fail_pend = 1'b1;
      next_s.fail_slot = fault.slot;
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.dior_q <= `FBM_RST_STROBE;
      s.diow_q <= `FBM_RST_STROBE;
      s.cursor <= `FBM_RST_CURSOR;
    end else begin
      s <= next_s;
    end
  end

  // Media array; contents survive reset like real flash
  always_ff @(posedge clock) begin
    if (mem_we) begin
      flash[mem_wa] <= mem_wd;
    end
  end

  // Checks on the block's own behaviour
  fbm_pkg::fbm_ecc_t chk1, chk2;
  assign chk1 = ecc_dec(ecc_enc(ata_in.dd) ^ (22'h000001 << ata_in.dd[4:0]));
  assign chk2 = ecc_dec(ecc_enc(ata_in.dd) ^ (22'h000003 << ata_in.dd[4:0]));

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_SPARE_HELD: assert property (
    s.state == fbm_pkg::FBM_WR_PROG && ff[4]
      |-> !s.used[{1'b0, ff[3:0]}] ##1 !s.l2p[s.lba][4])
    else $error("write went to a used or spare slot");
  AST_REMAP_COUNT: assert property (
    s.state == fbm_pkg::FBM_REMAP && !locked && !s.bad[s.fail_slot]
      |=> s.spares_used == $past(s.spares_used) + 3'h1)
    else $error("remap did not consume a spare");
  AST_LOCK_REFUSE: assert property (
    cmd_take && locked && ata_in.dd[7:0] == `FBM_CMD_WRITE
      |=> s.state == fbm_pkg::FBM_IDLE && s.err)
    else $error("write accepted while locked");
  AST_LOCK_READ: assert property (
    cmd_take && locked && ata_in.dd[7:0] == `FBM_CMD_READ
      |=> s.state == fbm_pkg::FBM_RD_FETCH)
    else $error("read refused while locked");
  AST_NEW_SLOT: assert property (
    s.state == fbm_pkg::FBM_WR_PROG && s.l2p_ok[s.lba] && ff[4]
      |-> {1'b0, ff[3:0]} != s.l2p[s.lba])
    else $error("rewrite reused the old slot");
  AST_MAP_NEW: assert property (
    s.state == fbm_pkg::FBM_WR_PROG && ff[4]
      |=> s.l2p[s.lba] == {1'b0, $past(ff[3:0])} && s.l2p_ok[s.lba])
    else $error("map not pointing at newest copy");
  AST_ECC_SINGLE: assert property (
    ata_in.dd[4:0] <= 5'h15 |-> chk1.data == ata_in.dd && !chk1.dbl)
    else $error("single-bit error not corrected");
  AST_ECC_DOUBLE: assert property (
    ata_in.dd[4:0] <= 5'h14 |-> chk2.dbl && !chk2.single)
    else $error("double-bit error not detected");
  AST_QUIET_BUS: assert property (
    ata_in.dior_n ##1 ata_in.dior_n |-> dd_oe_n)
    else $error("bus driven without read strobe");
  AST_STATUS_LOW: assert property (
    dior_fall && sel_ctl && ata_in.da == `FBM_DA_ALT
      |=> dd_out[15:8] == 8'h00 && dd_out[`FBM_ST_DRDY])
    else $error("register read not on low byte");
  AST_CAPTURE: assert property (
    diow_rise && sel_cmd && ata_in.da == `FBM_DA_LADDR
      && s.state == fbm_pkg::FBM_IDLE |=> s.lba == $past(ata_in.dd[2:0]))
    else $error("address not captured at strobe rise");
  AST_DRIVE: assert property (
    dior_fall && sel_cmd |=> !dd_oe_n)
    else $error("read data not driven after strobe fall");
  AST_DBL_ERR: assert property (
    s.state == fbm_pkg::FBM_RD_FETCH && rd_in_ready && s.l2p_ok[s.lba]
      && dec.dbl |=> s.err && !rd_out_valid)
    else $error("uncorrectable read not flagged");

  COV_WRITE: cover property (s.state == fbm_pkg::FBM_WR_PROG ##1
    s.state == fbm_pkg::FBM_IDLE);
  COV_READ: cover property (s.state == fbm_pkg::FBM_RD_FETCH ##1 rd_out_valid);
  COV_REMAP: cover property (s.state == fbm_pkg::FBM_REMAP
    && s.used[s.fail_slot]);
  COV_LOCK: cover property (locked && cmd_take);

endmodule : fbm_core

// File: fbm_host.sv
`include "fbm_cfg.svh"

module fbm_host (
  input wire logic clock,
  input wire logic [15:0] dd_out,
  input wire logic dd_oe_n,
  input wire logic iordy,
  output fbm_pkg::fbm_ata_in_t ata_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: both selects and both strobes high
  fbm_pkg::fbm_ata_in_t hst = 23'h7F0000;
  logic drv = 1'h0;
  logic stalled = 1'h0;
  logic [15:0] last = 16'h0000;

  // Bus level; an undriven bus toggles so no stale word passes
  always_comb begin
    ata_in = hst;
    if (!dd_oe_n) begin
      ata_in.dd = dd_out;
    end else if (!drv) begin
      ata_in.dd = ~last;
    end
  end

  always @(posedge clock) begin
    last <= ata_in.dd;
  end

  // Stretch the strobe while the device holds ready low
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clock);
    while (iordy !== 1'b1 && n < 64) begin
      @(negedge clock);
      n++;
    end
    stalled = (n != 0); // Seen by the bench as the ready witness
  endtask : wait_ready

  // Select, address and data held until after the rising strobe
  task automatic wr(input logic ctl, input logic [2:0] a,
                    input logic [15:0] d);
    @(posedge clock);
    hst.cs0_n <= ctl;
    hst.cs1_n <= !ctl;
    hst.da <= a;
    hst.dd <= d;
    drv <= 1'b1;
    hst.diow_n <= 1'b0;
    repeat (2) @(posedge clock);
    wait_ready();
    @(posedge clock);
    hst.diow_n <= 1'b1;
    @(posedge clock);
    hst.cs0_n <= 1'b1;
    hst.cs1_n <= 1'b1;
    drv <= 1'b0;
  endtask : wr

  // Data taken just before the read strobe rises
  task automatic rd(input logic ctl, input logic [2:0] a,
                    output logic [15:0] d, output logic oe_n);
    @(posedge clock);
    hst.cs0_n <= ctl;
    hst.cs1_n <= !ctl;
    hst.da <= a;
    drv <= 1'b0;
    hst.dior_n <= 1'b0;
    repeat (2) @(posedge clock);
    wait_ready();
    d = ata_in.dd;
    oe_n = dd_oe_n;
    @(posedge clock);
    hst.dior_n <= 1'b1;
    @(posedge clock);
    hst.cs0_n <= 1'b1;
    hst.cs1_n <= 1'b1;
  endtask : rd
endmodule : fbm_host

// File: fbm_core_bench.sv
`include "fbm_cfg.svh"

module fbm_core_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  fbm_pkg::fbm_ata_in_t ata_in;
  logic [15:0] dd_out;
  logic dd_oe_n;
  logic iordy;
  fbm_pkg::fbm_fault_t fault = 5'h00;
  logic [`FBM_CW_W-1:0] noise_mask = 22'h000000;
  logic locked;
  logic [2:0] spares_left;
  int failures = 0;
  int compares = 0;

  fbm_core DUT (.clock(clock), .sys_rst(sys_rst), .ata_in(ata_in),
    .dd_out(dd_out), .dd_oe_n(dd_oe_n), .iordy(iordy), .fault(fault),
    .noise_mask(noise_mask), .locked(locked), .spares_left(spares_left));

  fbm_host host (.clock(clock), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
    .iordy(iordy), .ata_in(ata_in));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Status polled until the engine drops busy, bounded
  task automatic wait_idle(output logic [15:0] s);
    logic oe;
    int n;
    n = 0;
    do begin
      host.rd(1'b0, `FBM_DA_CMD, s, oe);
      n++;
    end while (s[`FBM_ST_BSY] !== 1'b0 && n < 20);
    check(16'(s[`FBM_ST_BSY]), 16'h0000);
  endtask : wait_idle

  task automatic put(input logic [2:0] l, input logic [15:0] v,
                     input logic lock);
    logic [15:0] s;
    logic oe;
    host.wr(1'b0, `FBM_DA_LADDR, {13'h0000, l});
    host.wr(1'b0, `FBM_DA_CMD, {8'h00, `FBM_CMD_WRITE});
    host.rd(1'b0, `FBM_DA_CMD, s, oe);
    check(16'(s[`FBM_ST_DRQ]), 16'(!lock));
    if (!lock) begin
      host.wr(1'b0, `FBM_DA_DATA, v);
    end
    wait_idle(s);
    check(16'(s[`FBM_ST_ERR]), 16'(lock));
  endtask : put

  // Flags are the expected corrected and error status bits
  task automatic get(input logic [2:0] l, input logic [15:0] exp,
                     input logic [1:0] flags);
    logic [15:0] s;
    logic [15:0] d;
    logic oe;
    host.wr(1'b0, `FBM_DA_LADDR, {13'h0000, l});
    host.wr(1'b0, `FBM_DA_CMD, {8'h00, `FBM_CMD_READ});
    wait_idle(s);
    check(16'({s[`FBM_ST_CORR], s[`FBM_ST_ERR]}), 16'(flags));
    check(16'(s[15:8]), 16'h0000);
    if (!flags[0]) begin
      host.rd(1'b0, `FBM_DA_DATA, d, oe);
      check(d, exp);
      check(16'(oe), 16'h0000);
      check(16'(host.stalled), 16'h0000);
      repeat (2) @(posedge clock);
      check(16'(dd_oe_n), 16'h0001);
    end
  endtask : get

  task automatic t_reset();
    check(16'(locked), 16'h0000);
    check(16'(spares_left), 16'h0004);
    check(16'(dd_oe_n), 16'h0001);
    check(16'(iordy), 16'h0001);
  endtask : t_reset

  // Rewrites of one address; only the newest copy may come back
  task automatic t_rewrite();
    logic [15:0] s;
    logic oe;
    get(3'h3, 16'h0000, 2'h0);
    put(3'h3, 16'hA55A, 1'b0);
    put(3'h5, 16'h1234, 1'b0);
    put(3'h3, 16'h5AA5, 1'b0);
    get(3'h3, 16'h5AA5, 2'h0);
    get(3'h5, 16'h1234, 2'h0);
    host.rd(1'b1, `FBM_DA_ALT, s, oe);
    check(16'(s[`FBM_ST_DRDY]), 16'h0001);
  endtask : t_rewrite

  task automatic t_ecc();
    @(posedge clock);
    noise_mask <= 22'h000004;
    get(3'h5, 16'h1234, 2'h2);
    @(posedge clock);
    noise_mask <= 22'h000011;
    get(3'h5, 16'h0000, 2'h1);
    @(posedge clock);
    noise_mask <= 22'h000000;
    get(3'h5, 16'h1234, 2'h0);
  endtask : t_ecc

  task automatic t_badcmd();
    logic [15:0] s;
    host.wr(1'b0, `FBM_DA_CMD, 16'h00EC);
    wait_idle(s);
    check(16'(s[`FBM_ST_ERR]), 16'h0001);
  endtask : t_badcmd

  // Five failures against four spares; data must survive each swap
  task automatic t_spares();
    int left;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      fault <= '{req: 1'b1, slot: 4'(i)};
      @(posedge clock);
      fault.req <= 1'b0;
      repeat (4) @(posedge clock);
      left = (i < 4) ? 3 - i : 0;
      check(16'(spares_left), 16'(left));
      check(16'(locked), 16'(i >= 3));
      get(3'h3, 16'h5AA5, 2'h0);
      get(3'h5, 16'h1234, 2'h0);
    end
  endtask : t_spares

  task automatic t_lock();
    logic [15:0] s;
    logic oe;
    put(3'h6, 16'hBEEF, 1'b1);
    get(3'h6, 16'h0000, 2'h0);
    host.rd(1'b0, `FBM_DA_CMD, s, oe);
    check(16'(s[`FBM_ST_LOCK]), 16'h0001);
    // Empty read buffer: ready must hold the strobe off
    host.rd(1'b0, `FBM_DA_DATA, s, oe);
    check(16'(host.stalled), 16'h0001);
  endtask : t_lock

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_rewrite();
    t_ecc();
    t_badcmd();
    t_spares();
    t_lock();
    summarize();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    summarize();
  end
endmodule : fbm_core_bench
